// [rtl/cfsr_pkg.sv]
// package for the ccd field sequence register bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package cfsr_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 26;
  localparam int REGIONS  = 9;
  localparam int REG_A_N  = 5;
  localparam int SEQ_W    = 5;
  localparam int CTRL_W   = 2;
  localparam int POS_W    = 12;
  localparam int HI_LSB   = 13;
  localparam int LINE_W   = 13;
  localparam int GRP_W    = 5;
  localparam int MASK_LSB = 5;
  localparam int MASK_W   = 16;
  localparam int SEL_W    = 24;
  localparam int POS_REGS = 4;

  localparam logic [ADDR_W-1:0] OFS_SEQ_A    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SEQ_B    = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_POS_0_1  = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_POS8_LEN = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_LAST_SEC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GRP_MASK = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_GATE_SEL = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_ACT_LINE = 8'h0B;

  localparam logic [1:0] CTRL_SWEEP_BIT = 2'h1;
  localparam logic [1:0] CTRL_MULT_BIT  = 2'h2;

  typedef struct packed {
    logic [REGIONS-1:0][SEQ_W-1:0]  seq_select;
    logic [REGIONS-1:0][CTRL_W-1:0] repeat_scan_ctrl;
    logic [REGIONS-1:0][POS_W-1:0]  change_position;
    logic [POS_W-1:0]               field_line_count;
    logic [LINE_W-1:0]              final_line_length;
    logic [LINE_W-1:0]              second_pattern_start;
    logic [GRP_W-1:0]               second_pattern_group_select;
    logic [MASK_W-1:0]              gate_output_mask;
    logic [SEL_W-1:0]               gate_pattern_choice;
    logic [POS_W-1:0]               gate_active_line_first;
    logic [POS_W-1:0]               gate_active_line_second;
  } cfsr_cfg_t;

  typedef struct packed {
    cfsr_cfg_t          shadow;
    cfsr_cfg_t          active;
    logic [REGIONS-1:0] mult_en;
    logic [REGIONS-1:0] sweep_en;
    logic [DATA_W-1:0]  rd_data;
  } cfsr_state_t;

endpackage : cfsr_pkg

// [rtl/cfsr_field_regs.sv]
// field register bank with vertical sync update
`timescale 1ns/10ps
module cfsr_field_regs
(
  input  wire logic                           clk_in,
  input  wire logic                           rstn_in,
  input  wire logic                           wr_en_in,
  input  wire logic [cfsr_pkg::ADDR_W-1:0]    wr_addr_in,
  input  wire logic [cfsr_pkg::DATA_W-1:0]    wr_data_in,
  input  wire logic [cfsr_pkg::ADDR_W-1:0]    rd_addr_in,
  input  wire logic                           vertical_sync_in,
  output logic      [cfsr_pkg::DATA_W-1:0]    rd_data_out,
  output cfsr_pkg::cfsr_cfg_t                 active_cfg_out,
  output logic      [cfsr_pkg::REGIONS-1:0]   mult_en_out,
  output logic      [cfsr_pkg::REGIONS-1:0]   sweep_en_out
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  function automatic cfsr_pkg::cfsr_cfg_t apply_write(
    input cfsr_pkg::cfsr_cfg_t             c,
    input logic [cfsr_pkg::ADDR_W-1:0]     a,
    input logic [cfsr_pkg::DATA_W-1:0]     d
  );
    cfsr_pkg::cfsr_cfg_t r;
    r = c;
    if (a == cfsr_pkg::OFS_SEQ_A)
    begin
      for (int i = 0; i < cfsr_pkg::REG_A_N; i++)
        r.seq_select[i] = d[i*cfsr_pkg::SEQ_W +: cfsr_pkg::SEQ_W];
    end
    else if (a == cfsr_pkg::OFS_SEQ_B)
    begin
      for (int i = cfsr_pkg::REG_A_N; i < cfsr_pkg::REGIONS; i++)
        r.seq_select[i] =
          d[(i-cfsr_pkg::REG_A_N)*cfsr_pkg::SEQ_W +: cfsr_pkg::SEQ_W];
    end
    else if (a == cfsr_pkg::OFS_CTRL)
    begin
      for (int i = 0; i < cfsr_pkg::REGIONS; i++)
        r.repeat_scan_ctrl[i] = d[i*cfsr_pkg::CTRL_W +: cfsr_pkg::CTRL_W];
    end
    else if (a >= cfsr_pkg::OFS_POS_0_1 && a < cfsr_pkg::OFS_POS8_LEN)
    begin
      for (int k = 0; k < cfsr_pkg::POS_REGS; k++)
      begin
        if (a == cfsr_pkg::OFS_POS_0_1 + k[cfsr_pkg::ADDR_W-1:0])
        begin
          r.change_position[2*k]   = d[cfsr_pkg::POS_W-1:0];
          r.change_position[2*k+1] =
            d[cfsr_pkg::HI_LSB +: cfsr_pkg::POS_W];
        end
      end
    end
    else if (a == cfsr_pkg::OFS_POS8_LEN)
    begin
      r.change_position[cfsr_pkg::REGIONS-1] = d[cfsr_pkg::POS_W-1:0];
      r.field_line_count = d[cfsr_pkg::HI_LSB +: cfsr_pkg::POS_W];
    end
    else if (a == cfsr_pkg::OFS_LAST_SEC)
    begin
      r.final_line_length    = d[cfsr_pkg::LINE_W-1:0];
      r.second_pattern_start = d[cfsr_pkg::HI_LSB +: cfsr_pkg::LINE_W];
    end
    else if (a == cfsr_pkg::OFS_GRP_MASK)
    begin
      r.second_pattern_group_select = d[cfsr_pkg::GRP_W-1:0];
      r.gate_output_mask = d[cfsr_pkg::MASK_LSB +: cfsr_pkg::MASK_W];
    end
    else if (a == cfsr_pkg::OFS_GATE_SEL)
    begin
      r.gate_pattern_choice = d[cfsr_pkg::SEL_W-1:0];
    end
    else if (a == cfsr_pkg::OFS_ACT_LINE)
    begin
      r.gate_active_line_first  = d[cfsr_pkg::POS_W-1:0];
      r.gate_active_line_second = d[cfsr_pkg::HI_LSB +: cfsr_pkg::POS_W];
    end
    return r;
  endfunction : apply_write

  // --------------------------------------------------------------------------
  // read decode, unused bits and unmapped addresses read zero
  // --------------------------------------------------------------------------
  function automatic logic [cfsr_pkg::DATA_W-1:0] read_word(
    input cfsr_pkg::cfsr_cfg_t             c,
    input logic [cfsr_pkg::ADDR_W-1:0]     a
  );
    logic [cfsr_pkg::DATA_W-1:0] w;
    w = '0;
    if (a == cfsr_pkg::OFS_SEQ_A)
    begin
      for (int i = 0; i < cfsr_pkg::REG_A_N; i++)
        w[i*cfsr_pkg::SEQ_W +: cfsr_pkg::SEQ_W] = c.seq_select[i];
    end
    else if (a == cfsr_pkg::OFS_SEQ_B)
    begin
      for (int i = cfsr_pkg::REG_A_N; i < cfsr_pkg::REGIONS; i++)
        w[(i-cfsr_pkg::REG_A_N)*cfsr_pkg::SEQ_W +: cfsr_pkg::SEQ_W] = c.seq_select[i];
    end
    else if (a == cfsr_pkg::OFS_CTRL)
    begin
      for (int i = 0; i < cfsr_pkg::REGIONS; i++)
        w[i*cfsr_pkg::CTRL_W +: cfsr_pkg::CTRL_W] = c.repeat_scan_ctrl[i];
    end
    else if (a >= cfsr_pkg::OFS_POS_0_1 && a < cfsr_pkg::OFS_POS8_LEN)
    begin
      for (int k = 0; k < cfsr_pkg::POS_REGS; k++)
      begin
        if (a == cfsr_pkg::OFS_POS_0_1 + k[cfsr_pkg::ADDR_W-1:0])
        begin
          w[cfsr_pkg::POS_W-1:0] = c.change_position[2*k];
          w[cfsr_pkg::HI_LSB +: cfsr_pkg::POS_W] = c.change_position[2*k+1];
        end
      end
    end
    else if (a == cfsr_pkg::OFS_POS8_LEN)
    begin
      w[cfsr_pkg::POS_W-1:0] = c.change_position[cfsr_pkg::REGIONS-1];
      w[cfsr_pkg::HI_LSB +: cfsr_pkg::POS_W] = c.field_line_count;
    end
    else if (a == cfsr_pkg::OFS_LAST_SEC)
    begin
      w[cfsr_pkg::LINE_W-1:0] = c.final_line_length;
      w[cfsr_pkg::HI_LSB +: cfsr_pkg::LINE_W] = c.second_pattern_start;
    end
    else if (a == cfsr_pkg::OFS_GRP_MASK)
    begin
      w[cfsr_pkg::GRP_W-1:0] = c.second_pattern_group_select;
      w[cfsr_pkg::MASK_LSB +: cfsr_pkg::MASK_W] = c.gate_output_mask;
    end
    else if (a == cfsr_pkg::OFS_GATE_SEL)
    begin
      w[cfsr_pkg::SEL_W-1:0] = c.gate_pattern_choice;
    end
    else if (a == cfsr_pkg::OFS_ACT_LINE)
    begin
      w[cfsr_pkg::POS_W-1:0] = c.gate_active_line_first;
      w[cfsr_pkg::HI_LSB +: cfsr_pkg::POS_W] = c.gate_active_line_second;
    end
    return w;
  endfunction : read_word

  // --------------------------------------------------------------------------
  // state update
  // --------------------------------------------------------------------------
  cfsr_pkg::cfsr_state_t st;
  cfsr_pkg::cfsr_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (wr_en_in)
      next_st.shadow = apply_write(st.shadow, wr_addr_in, wr_data_in);
    if (vertical_sync_in)
      next_st.active = st.shadow;
    for (int i = 0; i < cfsr_pkg::REGIONS; i++)
    begin
      next_st.mult_en[i] =
        |(next_st.active.repeat_scan_ctrl[i] & cfsr_pkg::CTRL_MULT_BIT);
      next_st.sweep_en[i] =
        |(next_st.active.repeat_scan_ctrl[i] & cfsr_pkg::CTRL_SWEEP_BIT);
    end
    next_st.rd_data = read_word(st.shadow, rd_addr_in);
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign rd_data_out    = st.rd_data;
  assign active_cfg_out = st.active;
  assign mult_en_out    = st.mult_en;
  assign sweep_en_out   = st.sweep_en;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_write(logic [cfsr_pkg::ADDR_W-1:0] a);
    wr_en_in && wr_addr_in == a;
  endsequence

  sequence s_quiet;
    !vertical_sync_in && !wr_en_in;
  endsequence

  a_seq_a_store: assert property (s_write(cfsr_pkg::OFS_SEQ_A) |=>
    st.shadow.seq_select[4] == $past(wr_data_in[24:20]))
    else $error("region four select not stored");

  a_seq_b_store: assert property (s_write(cfsr_pkg::OFS_SEQ_B) |=>
    st.shadow.seq_select[8] == $past(wr_data_in[19:15]))
    else $error("region eight select not stored");

  a_ctrl_store: assert property (s_write(cfsr_pkg::OFS_CTRL) |=>
    st.shadow.repeat_scan_ctrl[8] == $past(wr_data_in[17:16]))
    else $error("region eight control not stored");

  a_ctrl_decode: assert property (vertical_sync_in |=>
    mult_en_out[0] == $past(st.shadow.repeat_scan_ctrl[0][1]) &&
    sweep_en_out[0] == $past(st.shadow.repeat_scan_ctrl[0][0]))
    else $error("region zero control decode wrong");

  a_pos_store: assert property (s_write(cfsr_pkg::OFS_POS_0_1 + 8'h02) |=>
    st.shadow.change_position[5] == $past(wr_data_in[24:13]) &&
    st.shadow.change_position[4] == $past(wr_data_in[11:0]))
    else $error("change positions four and five wrong");

  a_len_store: assert property (s_write(cfsr_pkg::OFS_POS8_LEN) |=>
    st.shadow.field_line_count == $past(wr_data_in[24:13]))
    else $error("field line count not stored");

  a_last_store: assert property (s_write(cfsr_pkg::OFS_LAST_SEC) |=>
    st.shadow.final_line_length == $past(wr_data_in[12:0]) &&
    st.shadow.second_pattern_start == $past(wr_data_in[25:13]))
    else $error("final line or second start wrong");

  a_mask_store: assert property (s_write(cfsr_pkg::OFS_GRP_MASK) |=>
    st.shadow.gate_output_mask == $past(wr_data_in[20:5]) &&
    st.shadow.second_pattern_group_select == $past(wr_data_in[4:0]))
    else $error("gate mask or group select wrong");

  a_gate_sel: assert property (s_write(cfsr_pkg::OFS_GATE_SEL) |=>
    st.shadow.gate_pattern_choice == $past(wr_data_in[23:0]))
    else $error("gate pattern choice wrong");

  a_held_sync: assert property (!vertical_sync_in |=> $stable(active_cfg_out))
    else $error("active set changed without sync");

  a_apply_sync: assert property (vertical_sync_in |=>
    active_cfg_out == $past(st.shadow))
    else $error("shadow not applied at sync");

endmodule : cfsr_field_regs

// [bench/cfsr_field_regs_tb_top.sv]
// self-checking bench for the field register bank
`timescale 1ns/10ps
module cfsr_field_regs_tb_top;
  localparam logic [11:0] LEN = 12'h3A0;
  localparam logic [12:0] FIN = 13'h1ABC;
  localparam logic [12:0] STA = 13'h0F35;
  localparam logic [4:0]  GRP = 5'h15;
  localparam logic [15:0] MSK = 16'hA5C3;
  localparam logic [23:0] SEL = 24'hC3A512;
  localparam logic [11:0] AL1 = 12'h123;
  localparam logic [11:0] AL2 = 12'h456;
  logic                clk_in;
  logic                rstn_in;
  logic                wr_en;
  logic [7:0]          wr_addr;
  logic [25:0]         wr_data;
  logic [7:0]          rd_addr;
  logic                vsync;
  logic [25:0]         rd_data;
  cfsr_pkg::cfsr_cfg_t act;
  logic [8:0]          mult;
  logic [8:0]          sweep;
  int                  err_total;
  int                  num_checks;
  cfsr_field_regs u_cfsr_field_regs (.clk_in(clk_in), .rstn_in(rstn_in), .wr_en_in(wr_en),
    .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_addr_in(rd_addr),
    .vertical_sync_in(vsync), .rd_data_out(rd_data), .active_cfg_out(act),
    .mult_en_out(mult), .sweep_en_out(sweep));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] sv(input int i);
    sv = 5'(i * 3 + 1);
  endfunction : sv
  function automatic logic [1:0] ct(input int i);
    ct = 2'(i);
  endfunction : ct
  function automatic logic [11:0] pv(input int i);
    pv = 12'(i * 40 + 8);
  endfunction : pv
  function automatic logic [25:0] wd(input int r);
    wd = '0;
    case (r)
      0: for (int k = 0; k < 5; k++) wd[5*k+:5] = sv(k);
      1: for (int k = 0; k < 4; k++) wd[5*k+:5] = sv(k + 5);
      2: for (int k = 0; k < 9; k++) wd[2*k+:2] = ct(k);
      3, 4, 5, 6: wd = {1'b0, pv(2 * (r - 3) + 1), 1'b0, pv(2 * (r - 3))};
      7: wd = {1'b0, LEN, 1'b0, pv(8)};
      8: wd = {STA, FIN};
      9: wd = {5'h00, MSK, GRP};
      10: wd = {2'h0, SEL};
      11: wd = {1'b0, AL2, 1'b0, AL1};
      default: wd = '0;
    endcase
  endfunction : wd
  task automatic chk(input string n, input logic [25:0] e, input logic [25:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [25:0] e);
    @(posedge clk_in);
    rd_addr <= a;
    @(posedge clk_in);
    @(negedge clk_in);
    chk($sformatf("rd_data_%0d", a), e, rd_data);
  endtask : rd
  task automatic sync_pulse();
    @(posedge clk_in);
    vsync <= 1'b1;
    @(posedge clk_in);
    vsync <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask : sync_pulse
  task automatic chk_active(input logic [23:0] sel_e, input logic zero);
    logic [8:0] me;
    logic [8:0] se;
    for (int k = 0; k < 9; k++)
    begin
      me[k] = !zero && (ct(k) == 2'h2 || ct(k) == 2'h3);
      se[k] = !zero && (ct(k) == 2'h1 || ct(k) == 2'h3);
      chk("seq_select", zero ? 26'h0 : 26'(sv(k)), 26'(act.seq_select[k]));
      chk("repeat_ctrl", zero ? 26'h0 : 26'(ct(k)), 26'(act.repeat_scan_ctrl[k]));
      chk("change_pos", zero ? 26'h0 : 26'(pv(k)), 26'(act.change_position[k]));
    end
    chk("mult_en", 26'(me), 26'(mult));
    chk("sweep_en", 26'(se), 26'(sweep));
    chk("line_count", zero ? 26'h0 : 26'(LEN), 26'(act.field_line_count));
    chk("final_len", zero ? 26'h0 : 26'(FIN), 26'(act.final_line_length));
    chk("second_start", zero ? 26'h0 : 26'(STA), 26'(act.second_pattern_start));
    chk("second_grp", zero ? 26'h0 : 26'(GRP), 26'(act.second_pattern_group_select));
    chk("gate_mask", zero ? 26'h0 : 26'(MSK), 26'(act.gate_output_mask));
    chk("gate_sel", 26'(sel_e), 26'(act.gate_pattern_choice));
    chk("act_first", zero ? 26'h0 : 26'(AL1), 26'(act.gate_active_line_first));
    chk("act_second", zero ? 26'h0 : 26'(AL2), 26'(act.gate_active_line_second));
  endtask : chk_active
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write_all_held();
    for (int r = 0; r < 13; r++)
    begin
      @(posedge clk_in);
      wr_en   <= 1'b1;
      wr_addr <= 8'(r);
      wr_data <= (r == 12) ? 26'h3FFFFFF : wd(r);
    end
    @(posedge clk_in);
    wr_en <= 1'b0;
    for (int r = 0; r < 13; r++)
      rd(8'(r), wd(r));
    chk_active(24'h000000, 1'b1);
  endtask : t_write_all_held
  task automatic t_apply_at_sync();
    sync_pulse();
    chk_active(SEL, 1'b0);
  endtask : t_apply_at_sync
  task automatic t_write_with_sync();
    @(posedge clk_in);
    wr_en   <= 1'b1;
    wr_addr <= 8'h0A;
    wr_data <= 26'h05A5A5A;
    vsync   <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
    vsync <= 1'b0;
    rd(8'h0A, 26'h05A5A5A);
    chk_active(SEL, 1'b0);
    sync_pulse();
    chk_active(24'h5A5A5A, 1'b0);
  endtask : t_write_with_sync
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial
  begin
    #40000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    err_total  = 0;
    num_checks = 0;
    rstn_in    = 1'b0;
    wr_en      = 1'b0;
    wr_addr    = 8'h00;
    wr_data    = 26'h0;
    rd_addr    = 8'h00;
    vsync      = 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk_active(24'h000000, 1'b1);
    chk("rd_reset", 26'h0, rd_data);
    t_write_all_held();
    t_apply_at_sync();
    t_write_with_sync();
    report_and_stop();
  end
endmodule : cfsr_field_regs_tb_top
